// File: rois_checker.sv
// rois_checker.sv - assertions on the relay output item selector ports
// assumes: bound to rois_relay_select; item registers mirrored from bus writes
`timescale 1ns/1ns
`include "rois_map.vh"
module rois_checker (
    input wire        clock_i,
    input wire        rst_n_i,
    input wire        hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0]  htrans_i,
    input wire        hwrite_i,
    input wire [31:0] hwdata_i,
    input wire        hready_i,
    input wire        fire_mode_i,
    input wire        energy_buffering_i,
    input wire        warning_i,
    input wire        brake_release_i,
    input wire        run_cmd_i,
    input wire        volt_out_i,
    input wire        dc_brake_i,
    input wire        relay_one_o,
    input wire        relay_two_o
);
    reg [5:0] it1_reg;
    reg [5:0] it2_reg;
    reg [7:0] wa_reg;
    reg       wv_reg;
    // ----
    // item mirror
    // ----
    always @(posedge clock_i) begin
        wa_reg <= haddr_i[7:0];
        if (!rst_n_i) begin
            it1_reg <= `ROIS_RST_RLY1_ITEM;
            it2_reg <= `ROIS_RST_RLY2_ITEM;
            wv_reg <= 1'b0;
        end else begin
            wv_reg <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
            if (wv_reg && wa_reg == `ROIS_ADDR_RLY1_ITEM)
                it1_reg <= hwdata_i[5:0];
            if (wv_reg && wa_reg == `ROIS_ADDR_RLY2_ITEM)
                it2_reg <= hwdata_i[5:0];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    property p_sel(logic [5:0] it, logic [5:0] code, logic rly, logic cond);
        $past(rst_n_i) && $past(it) == code |-> rly == $past(cond);
    endproperty
    AST_FIRE: assert property (p_sel(it1_reg, `ROIS_ITEM_FIRE, relay_one_o, fire_mode_i))
        else $error("relay one ignores fire mode");
    AST_FIRE_RISE: assert property ($rose(fire_mode_i) && it1_reg == `ROIS_ITEM_FIRE
        && $past(rst_n_i) |=> relay_one_o) else $error("relay one late on fire mode");
    AST_ENERGY_BUF: assert property (p_sel(it2_reg, `ROIS_ITEM_ENERGY_BUF, relay_two_o,
        energy_buffering_i))
        else $error("relay two ignores buffering");
    AST_MINOR: assert property (p_sel(it1_reg, `ROIS_ITEM_MINOR, relay_one_o, warning_i))
        else $error("relay one ignores warning");
    AST_BRAKE: assert property (p_sel(it2_reg, `ROIS_ITEM_BRAKE, relay_two_o, brake_release_i))
        else $error("relay two ignores brake release");
    AST_RUN: assert property (p_sel(it2_reg, `ROIS_ITEM_RUN, relay_two_o,
        run_cmd_i & volt_out_i & ~dc_brake_i)) else $error("relay two run mismatch");
    AST_OFF_ONE: assert property ($past(rst_n_i) && $past(it1_reg) == 6'h3F |-> !relay_one_o)
        else $error("relay one on for unlisted item");
    AST_OFF_TWO: assert property ($past(rst_n_i) && $past(it2_reg) == 6'h3F |-> !relay_two_o)
        else $error("relay two on for unlisted item");
    cover property (it1_reg == `ROIS_ITEM_FIRE && relay_one_o);
    cover property (it2_reg == `ROIS_ITEM_ENERGY_BUF && relay_two_o);
    cover property (it2_reg == `ROIS_ITEM_RUN && relay_two_o);
endmodule
bind rois_relay_select rois_checker i_chk (.clock_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hwdata_i, .hready_i, .fire_mode_i, .energy_buffering_i, .warning_i,
    .brake_release_i, .run_cmd_i, .volt_out_i, .dc_brake_i, .relay_one_o, .relay_two_o);

// File: rois_load.sv
// rois_load.sv - equipment wired to the two relay contacts
// assumes: contacts sampled on the system clock
`timescale 1ns/1ns
module rois_load (
    input  wire       clock_i,
    input  wire       coil_one_i,
    input  wire       coil_two_i,
    output reg  [7:0] closes_o
);
    reg [1:0] last_reg = 2'h0;
    initial closes_o = 8'h00;
    // counts contact closures of either relay
    always @(posedge clock_i) begin
        last_reg <= {coil_two_i, coil_one_i};
        closes_o <= closes_o + {7'h00, coil_one_i & ~last_reg[0]}
            + {7'h00, coil_two_i & ~last_reg[1]};
    end
endmodule

// File: rois_map.vh
// rois_map.vh - register map, field positions, reset values and timing counts
// assumes: included by the relay output item selector design files
`ifndef ROIS_MAP_VH
`define ROIS_MAP_VH

`define ROIS_ADDR_TRIP_MODE   8'h00
`define ROIS_ADDR_RLY1_ITEM   8'h04
`define ROIS_ADDR_RLY2_ITEM   8'h08
`define ROIS_ADDR_ON_DELAY    8'h0C
`define ROIS_ADDR_OFF_DELAY   8'h10
`define ROIS_ADDR_ZSPD_FREQ   8'h14
`define ROIS_ADDR_ZSPD_BAND   8'h18
`define ROIS_ADDR_TIMER_DLY   8'h1C
`define ROIS_ADDR_ANA_ON      8'h20
`define ROIS_ADDR_ANA_OFF     8'h24
`define ROIS_ADDR_STATUS      8'h28

`define ROIS_ITEM_RUN         6'h0E
`define ROIS_ITEM_ZSPD        6'h17
`define ROIS_ITEM_TIMER       6'h1C
`define ROIS_ITEM_TRIP        6'h1D
`define ROIS_ITEM_ANALOG      6'h22
`define ROIS_ITEM_BRAKE       6'h23
`define ROIS_ITEM_FIRE        6'h26
`define ROIS_ITEM_ENERGY_BUF  6'h28
`define ROIS_ITEM_MINOR       6'h2A

`define ROIS_RST_RLY1_ITEM    6'h1D
`define ROIS_RST_RLY2_ITEM    6'h0E
`define ROIS_RST_TRIP_MODE    3'h0

`define ROIS_BIT_LV           0
`define ROIS_BIT_OTHER        2
`define ROIS_BIT_RESTART      3

`define ROIS_TICK_NS          10000000
`define ROIS_CLK_NS           10
`define ROIS_TICK_CYCLES      (`ROIS_TICK_NS / `ROIS_CLK_NS)
`define ROIS_DELAY_MAX        16'h2710

`endif

// File: rois_relay_select.v
// rois_relay_select.v - output item selection for two multi-function relays
// assumes: status inputs synchronous to clock_i, one AHB-Lite master
`timescale 1ns/1ns
`include "rois_map.vh"

module rois_relay_select #(
    parameter TICK_CYCLES = `ROIS_TICK_CYCLES,
    parameter FREQ_W      = 16,
    parameter ANA_W       = 12
) (
    input  wire              clock_i,
    input  wire              rst_n_i,
    input  wire              hsel_i,
    input  wire [31:0]       haddr_i,
    input  wire [1:0]        htrans_i,
    input  wire              hwrite_i,
    input  wire [2:0]        hsize_i,
    input  wire [31:0]       hwdata_i,
    input  wire              hready_i,
    output reg  [31:0]       hrdata_o,
    output reg               hreadyout_o,
    output reg               hresp_o,
    input  wire [FREQ_W-1:0] out_freq_i,
    input  wire              timer_in_i,
    input  wire              trip_lv_i,
    input  wire              trip_other_i,
    input  wire              restart_fail_i,
    input  wire [ANA_W-1:0]  analog_i,
    input  wire              brake_release_i,
    input  wire              fire_mode_i,
    input  wire              energy_buffering_i,
    input  wire              warning_i,
    input  wire              run_cmd_i,
    input  wire              volt_out_i,
    input  wire              dc_brake_i,
    output reg               relay_one_o,
    output reg               relay_two_o
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [2:0]        trip_out_mode_field_reg;
reg [5:0]        relay_one_item_reg;
reg [5:0]        relay_two_item_reg;
reg [15:0]       trip_out_on_delay_reg;
reg [15:0]       trip_out_off_delay_reg;
reg [FREQ_W-1:0] zspd_freq_reg;
reg [FREQ_W-1:0] zspd_band_reg;
reg [15:0]       timer_dly_reg;
reg [ANA_W-1:0]  ana_on_reg;
reg [ANA_W-1:0]  ana_off_reg;
reg              wr_pend_reg;
reg [7:0]        wr_addr_reg;
reg [31:0]       tick_cnt_reg;
reg              tick_reg;
reg [15:0]       trip_cnt_reg;
reg              trip_out_reg;
reg [15:0]       tmr_cnt_reg;
reg              tmr_out_reg;
reg              ana_out_reg;
reg [31:0]       tick_cnt_next;
reg              tick_next;
reg [15:0]       trip_cnt_next;
reg              trip_out_next;
reg [15:0]       tmr_cnt_next;
reg              tmr_out_next;
reg              ana_out_next;
reg              relay_one_next;
reg              relay_two_next;

wire [7:0]  bus_addr = haddr_i[7:0];
wire        bus_req  = hsel_i & hready_i & htrans_i[1];

function [15:0] clip_delay;
    input [31:0] value;
    begin
        if (value[15:0] > `ROIS_DELAY_MAX || value[31:16] != 16'h0000) begin
            clip_delay = `ROIS_DELAY_MAX;
        end else begin
            clip_delay = value[15:0];
        end
    end
endfunction

// ----------------------------------------------------------------
// ahb-lite slave, zero wait states, always okay
// ----------------------------------------------------------------
always @(posedge clock_i) begin
    if (!rst_n_i) begin
        wr_pend_reg             <= 1'b0;
        wr_addr_reg             <= 8'h00;
        hrdata_o                <= 32'h00000000;
        hreadyout_o             <= 1'b1;
        hresp_o                 <= 1'b0;
        trip_out_mode_field_reg <= `ROIS_RST_TRIP_MODE;
        relay_one_item_reg      <= `ROIS_RST_RLY1_ITEM;
        relay_two_item_reg      <= `ROIS_RST_RLY2_ITEM;
        trip_out_on_delay_reg   <= 16'h0000;
        trip_out_off_delay_reg  <= 16'h0000;
        zspd_freq_reg           <= {FREQ_W{1'b0}};
        zspd_band_reg           <= {FREQ_W{1'b0}};
        timer_dly_reg           <= 16'h0000;
        ana_on_reg              <= {ANA_W{1'b0}};
        ana_off_reg             <= {ANA_W{1'b0}};
    end else begin
        hreadyout_o <= 1'b1;
        hresp_o     <= 1'b0;
        wr_pend_reg <= bus_req & hwrite_i;
        if (bus_req) begin
            wr_addr_reg <= bus_addr;
        end
        if (bus_req && !hwrite_i) begin
            case (bus_addr)
                `ROIS_ADDR_TRIP_MODE: hrdata_o <= {29'h0, trip_out_mode_field_reg};
                `ROIS_ADDR_RLY1_ITEM: hrdata_o <= {26'h0, relay_one_item_reg};
                `ROIS_ADDR_RLY2_ITEM: hrdata_o <= {26'h0, relay_two_item_reg};
                `ROIS_ADDR_ON_DELAY:  hrdata_o <= {16'h0, trip_out_on_delay_reg};
                `ROIS_ADDR_OFF_DELAY: hrdata_o <= {16'h0, trip_out_off_delay_reg};
                `ROIS_ADDR_ZSPD_FREQ: hrdata_o <= {{(32-FREQ_W){1'b0}}, zspd_freq_reg};
                `ROIS_ADDR_ZSPD_BAND: hrdata_o <= {{(32-FREQ_W){1'b0}}, zspd_band_reg};
                `ROIS_ADDR_TIMER_DLY: hrdata_o <= {16'h0, timer_dly_reg};
                `ROIS_ADDR_ANA_ON:    hrdata_o <= {{(32-ANA_W){1'b0}}, ana_on_reg};
                `ROIS_ADDR_ANA_OFF:   hrdata_o <= {{(32-ANA_W){1'b0}}, ana_off_reg};
                `ROIS_ADDR_STATUS:    hrdata_o <= {26'h0, trip_out_reg, tmr_out_reg,
                                                   ana_out_reg, trip_out_reg,
                                                   relay_two_o, relay_one_o};
                default:              hrdata_o <= 32'h00000000;
            endcase
        end
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `ROIS_ADDR_TRIP_MODE: trip_out_mode_field_reg <= {hwdata_i[`ROIS_BIT_RESTART],
                                                                  hwdata_i[`ROIS_BIT_OTHER],
                                                                  hwdata_i[`ROIS_BIT_LV]};
                `ROIS_ADDR_RLY1_ITEM: relay_one_item_reg      <= hwdata_i[5:0];
                `ROIS_ADDR_RLY2_ITEM: relay_two_item_reg      <= hwdata_i[5:0];
                `ROIS_ADDR_ON_DELAY:  trip_out_on_delay_reg   <= clip_delay(hwdata_i);
                `ROIS_ADDR_OFF_DELAY: trip_out_off_delay_reg  <= clip_delay(hwdata_i);
                `ROIS_ADDR_ZSPD_FREQ: zspd_freq_reg           <= hwdata_i[FREQ_W-1:0];
                `ROIS_ADDR_ZSPD_BAND: zspd_band_reg           <= hwdata_i[FREQ_W-1:0];
                `ROIS_ADDR_TIMER_DLY: timer_dly_reg           <= hwdata_i[15:0];
                `ROIS_ADDR_ANA_ON:    ana_on_reg              <= hwdata_i[ANA_W-1:0];
                `ROIS_ADDR_ANA_OFF:   ana_off_reg             <= hwdata_i[ANA_W-1:0];
                default:              ;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// 10 ms tick
// ----------------------------------------------------------------
// free-running time base shared by every delay counter
always @* begin
    if (tick_cnt_reg >= TICK_CYCLES - 1) begin
        tick_cnt_next = 32'h00000000;
        tick_next     = 1'b1;
    end else begin
        tick_cnt_next = tick_cnt_reg + 32'h00000001;
        tick_next     = 1'b0;
    end
end

always @(posedge clock_i) begin
    if (!rst_n_i) begin
        tick_cnt_reg <= 32'h00000000;
        tick_reg     <= 1'b0;
    end else begin
        tick_cnt_reg <= tick_cnt_next;
        tick_reg     <= tick_next;
    end
end

// ----------------------------------------------------------------
// trip output with on and off delay
// ----------------------------------------------------------------
wire trip_cond = (trip_out_mode_field_reg[0] & trip_lv_i) |
                 (trip_out_mode_field_reg[1] & trip_other_i) |
                 (trip_out_mode_field_reg[2] & restart_fail_i);

wire [15:0] trip_target = trip_cond ? trip_out_on_delay_reg : trip_out_off_delay_reg;

// the count restarts whenever the condition matches the output again,
// so a short glitch never adds up toward a change
always @* begin
    trip_cnt_next = trip_cnt_reg;
    trip_out_next = trip_out_reg;
    if (trip_cond == trip_out_reg) begin
        trip_cnt_next = 16'h0000;
    end else if (trip_cnt_reg >= trip_target) begin
        trip_cnt_next = 16'h0000;
        trip_out_next = trip_cond;
    end else if (tick_reg) begin
        trip_cnt_next = trip_cnt_reg + 16'h0001;
    end
end

always @(posedge clock_i) begin
    if (!rst_n_i) begin
        trip_cnt_reg <= 16'h0000;
        trip_out_reg <= 1'b0;
    end else begin
        trip_cnt_reg <= trip_cnt_next;
        trip_out_reg <= trip_out_next;
    end
end

// ----------------------------------------------------------------
// timer item and analog hysteresis
// ----------------------------------------------------------------
// the timer output drops at once when its trigger falls
always @* begin
    tmr_cnt_next = tmr_cnt_reg;
    tmr_out_next = tmr_out_reg;
    ana_out_next = ana_out_reg;
    if (!timer_in_i) begin
        tmr_cnt_next = 16'h0000;
        tmr_out_next = 1'b0;
    end else if (tmr_cnt_reg >= timer_dly_reg) begin
        tmr_out_next = 1'b1;
    end else if (tick_reg) begin
        tmr_cnt_next = tmr_cnt_reg + 16'h0001;
    end
    // the on level wins when both levels are met
    if (analog_i >= ana_on_reg) begin
        ana_out_next = 1'b1;
    end else if (analog_i <= ana_off_reg) begin
        ana_out_next = 1'b0;
    end
end

always @(posedge clock_i) begin
    if (!rst_n_i) begin
        tmr_cnt_reg <= 16'h0000;
        tmr_out_reg <= 1'b0;
        ana_out_reg <= 1'b0;
    end else begin
        tmr_cnt_reg <= tmr_cnt_next;
        tmr_out_reg <= tmr_out_next;
        ana_out_reg <= ana_out_next;
    end
end

// ----------------------------------------------------------------
// item selection
// ----------------------------------------------------------------
wire [FREQ_W:0] zspd_limit = {1'b0, zspd_freq_reg} + {1'b0, zspd_band_reg};
wire            zspd_cond  = {1'b0, out_freq_i} < zspd_limit;

// one flag per listed item, passed in so the selector reads nothing else
wire [8:0]      item_flags = {warning_i,
                              energy_buffering_i,
                              fire_mode_i,
                              brake_release_i,
                              ana_out_reg,
                              trip_out_reg,
                              tmr_out_reg,
                              zspd_cond,
                              run_cmd_i & volt_out_i & ~dc_brake_i};

function item_cond;
    input [5:0] item;
    input [8:0] flags;
    begin
        case (item)
            `ROIS_ITEM_RUN:        item_cond = flags[0];
            `ROIS_ITEM_ZSPD:       item_cond = flags[1];
            `ROIS_ITEM_TIMER:      item_cond = flags[2];
            `ROIS_ITEM_TRIP:       item_cond = flags[3];
            `ROIS_ITEM_ANALOG:     item_cond = flags[4];
            `ROIS_ITEM_BRAKE:      item_cond = flags[5];
            `ROIS_ITEM_FIRE:       item_cond = flags[6];
            `ROIS_ITEM_ENERGY_BUF: item_cond = flags[7];
            `ROIS_ITEM_MINOR:      item_cond = flags[8];
            default:               item_cond = 1'b0;
        endcase
    end
endfunction

always @* begin
    relay_one_next = item_cond(relay_one_item_reg, item_flags);
    relay_two_next = item_cond(relay_two_item_reg, item_flags);
end

always @(posedge clock_i) begin
    if (!rst_n_i) begin
        relay_one_o <= 1'b0;
        relay_two_o <= 1'b0;
    end else begin
        relay_one_o <= relay_one_next;
        relay_two_o <= relay_two_next;
    end
end

endmodule

// File: tb.sv
// tb.sv - self-checking bench for the relay output item selector
// assumes: zero-wait AHB-Lite slave, tick of 4 cycles
`timescale 1ns/1ns
`include "rois_map.vh"
module tb;
    localparam [35:0] ITEMS = {6'h3F, `ROIS_ITEM_RUN, `ROIS_ITEM_BRAKE,
        `ROIS_ITEM_MINOR, `ROIS_ITEM_ENERGY_BUF, `ROIS_ITEM_FIRE};
    reg         clock_i = 1'b0;
    reg         rst_n_i = 1'b0;
    reg         hsel_i = 1'b0;
    reg  [31:0] haddr_i = 32'h0;
    reg  [1:0]  htrans_i = 2'h0;
    reg         hwrite_i = 1'b0;
    reg  [31:0] hwdata_i = 32'h0;
    reg  [15:0] out_freq_i = 16'h0;
    reg  [11:0] analog_i = 12'h0;
    reg  [10:0] st = 11'h0;
    wire [31:0] hrdata_o;
    wire        hreadyout_o;
    wire        hresp_o;
    wire        relay_one_o;
    wire        relay_two_o;
    wire [7:0]  closes;
    integer     seed, n_errors, n_checks, i, k;
    integer     cyc = 0;
    reg  [31:0] rd;
    rois_relay_select #(.TICK_CYCLES(4)) i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .out_freq_i(out_freq_i),
        .timer_in_i(st[10]), .trip_lv_i(st[9]), .trip_other_i(st[8]),
        .restart_fail_i(st[7]), .analog_i(analog_i), .brake_release_i(st[6]),
        .fire_mode_i(st[5]), .energy_buffering_i(st[4]), .warning_i(st[3]),
        .run_cmd_i(st[2]), .volt_out_i(st[1]), .dc_brake_i(st[0]),
        .relay_one_o(relay_one_o), .relay_two_o(relay_two_o));
    rois_load i_load (.clock_i(clock_i), .coil_one_i(relay_one_o),
        .coil_two_i(relay_two_o), .closes_o(closes));
    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc = cyc + 1;
        if (cyc > 20000) begin
            n_errors = n_errors + 1;
            print_verdict;
        end
    end
    task print_verdict;
        begin
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clock_i);
            hsel_i <= 1'b1;
            haddr_i <= {24'h0, a};
            htrans_i <= 2'h2;
            hwrite_i <= w;
            @(posedge clock_i);
            while (hreadyout_o !== 1'b1) @(posedge clock_i);
            hsel_i <= 1'b0;
            htrans_i <= 2'h0;
            hwdata_i <= d;
            @(posedge clock_i);
            while (hreadyout_o !== 1'b1) @(posedge clock_i);
            rd = hrdata_o;
            chk(hresp_o, 0);
        end
    endtask
    // waits n cycles, checks one relay, returns on a clock edge
    task sc(input s, input v, input integer n);
        begin
            repeat (n) @(posedge clock_i);
            #1 chk(s ? relay_two_o : relay_one_o, v);
            @(posedge clock_i);
        end
    endtask
    function ex(input [5:0] it, input [10:0] s);
        case (it)
            `ROIS_ITEM_FIRE:  ex = s[5];
            `ROIS_ITEM_ENERGY_BUF: ex = s[4];
            `ROIS_ITEM_MINOR: ex = s[3];
            `ROIS_ITEM_BRAKE: ex = s[6];
            `ROIS_ITEM_RUN:   ex = s[2] & s[1] & ~s[0];
            default:          ex = 1'b0;
        endcase
    endfunction
    initial begin
        seed = 32'hd91f607c;
        n_errors = 0;
        n_checks = 0;
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        bus(0, `ROIS_ADDR_RLY1_ITEM, 0);
        chk(rd, `ROIS_RST_RLY1_ITEM);
        bus(0, 8'h3C, 0);
        chk(rd, 0);
        for (i = 0; i < 24; i = i + 1) begin
            bus(1, (i / 6) % 2 ? `ROIS_ADDR_RLY2_ITEM : `ROIS_ADDR_RLY1_ITEM, ITEMS[6*(i%6) +: 6]);
            rd = $random(seed);
            st <= rd[10:0];
            sc((i / 6) % 2 == 1, ex(ITEMS[6*(i%6) +: 6], rd[10:0]), 2);
        end
        st <= 11'h000;
        bus(1, `ROIS_ADDR_RLY1_ITEM, `ROIS_ITEM_TRIP);
        for (i = 0; i < 9; i = i + 1) begin
            bus(1, `ROIS_ADDR_TRIP_MODE, 32'h1 << ((i / 3) ? i / 3 + 1 : 0));
            st <= 11'h200 >> (i % 3);
            sc(0, i / 3 == i % 3, 4);
            st <= 11'h000;
            sc(0, 0, 4);
        end
        bus(1, `ROIS_ADDR_ON_DELAY, 32'hFFFF);
        bus(0, `ROIS_ADDR_ON_DELAY, 0);
        chk(rd, `ROIS_DELAY_MAX);
        bus(1, `ROIS_ADDR_ON_DELAY, 2);
        bus(1, `ROIS_ADDR_OFF_DELAY, 3);
        // trip mode still enables only the restart failure category here
        st <= 11'h080;
        sc(0, 0, 3);
        sc(0, 1, 10);
        bus(0, `ROIS_ADDR_STATUS, 0);
        chk(rd, 32'h0000002D);
        st <= 11'h000;
        sc(0, 1, 3);
        sc(0, 0, 14);
        bus(1, `ROIS_ADDR_RLY2_ITEM, `ROIS_ITEM_ZSPD);
        bus(1, `ROIS_ADDR_ZSPD_FREQ, 100);
        bus(1, `ROIS_ADDR_ZSPD_BAND, 20);
        out_freq_i <= 16'd119;
        sc(1, 1, 3);
        out_freq_i <= 16'd120;
        sc(1, 0, 3);
        bus(1, `ROIS_ADDR_RLY2_ITEM, `ROIS_ITEM_TIMER);
        bus(1, `ROIS_ADDR_TIMER_DLY, 3);
        st <= 11'h400;
        sc(1, 0, 4);
        sc(1, 1, 12);
        st <= 11'h000;
        sc(1, 0, 3);
        bus(1, `ROIS_ADDR_RLY2_ITEM, `ROIS_ITEM_ANALOG);
        bus(1, `ROIS_ADDR_ANA_ON, 100);
        bus(1, `ROIS_ADDR_ANA_OFF, 50);
        for (i = 0; i < 3; i = i + 1) begin
            analog_i <= (i == 0) ? 12'd150 : (i == 1) ? 12'd75 : 12'd30;
            sc(1, i < 2, 3);
        end
        chk(closes != 8'h00, 1);
        print_verdict;
    end
endmodule
